// ---- include/spms_pkg.sv ----
// Package for the master/slave serial peripheral interface core
package spms_pkg;

   // ----------------------------------------
   // Word and select geometry
   // ----------------------------------------
   localparam int unsigned WORD_BITS = 8;
   localparam int unsigned SEL_COUNT = 8;
   localparam int unsigned DIV_BITS  = 8;

   // ----------------------------------------
   // Reset values and timing counts
   // ----------------------------------------
   localparam logic [SEL_COUNT-1:0] SEL_IDLE    = 8'hff;
   localparam logic [DIV_BITS-1:0]  DIV_MIN     = 8'h01;
   localparam logic [3:0]           BIT_CNT_RST = 4'h0;
   localparam logic [3:0]           BIT_LAST    = 4'h8;

   // ----------------------------------------
   // Types
   // ----------------------------------------
   typedef logic [WORD_BITS-1:0] spms_word_t;

   typedef struct packed {
      logic       master;    // 1 = master, 0 = slave
      logic       lsb_first; // 1 = LSB first
      logic [2:0] sel_index; // Which slave select to drive
      logic [DIV_BITS-1:0] half_div; // System clocks per half serial period
   } spms_cfg_t;

   typedef enum logic [1:0] {
      ST_IDLE  = 2'b00,
      ST_LOW   = 2'b01,
      ST_HIGH  = 2'b10,
      ST_DONE  = 2'b11
   } spms_state_t;

endpackage

// ---- hdl/spms_core.sv ----
// Master/slave serial peripheral interface core, mode 0, one clock domain
`timescale 1ns/1ns
module spms_core
   import spms_pkg::*;
(
   // Clock and reset
   input  wire logic                clock_in,
   input  wire logic                rst_n_in,
   // Configuration
   input  wire spms_pkg::spms_cfg_t cfg_in,
   // Transmit word from user
   input  wire spms_pkg::spms_word_t tx_data_in,
   input  wire logic                tx_valid_in,
   output logic                     tx_ready_out,
   // Received word to user
   output spms_pkg::spms_word_t     rx_data_out,
   output logic                     rx_valid_out,
   input  wire logic                rx_ready_in,
   // Serial pins
   output logic                     sck_out,
   output logic                     sck_oe_out,
   output logic [SEL_COUNT-1:0]     sel_n_out,
   output logic                     mosi_out,
   output logic                     miso_out,
   output logic                     miso_oe_out,
   input  wire logic                sck_in,
   input  wire logic                sel_n_in,
   input  wire logic                mosi_in,
   input  wire logic                miso_in
);
   import spms_pkg::*;

   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   // Bit of the word on the wire at position n
   function automatic logic pick_bit(input spms_word_t w, input logic [3:0] n, input logic lsb);
      logic [2:0] idx;
      idx = lsb ? n[2:0] : 3'(WORD_BITS - 1 - 32'(n[2:0]));
      return w[idx];
   endfunction

   // Place received bit at position n
   function automatic spms_word_t put_bit(input spms_word_t w, input logic [3:0] n, input logic lsb,
                                         input logic b);
      spms_word_t r;
      r = w;
      r[lsb ? n[2:0] : 3'(WORD_BITS - 1 - 32'(n[2:0]))] = b;
      return r;
   endfunction

   // Shift a received bit in from the end that fills last
   function automatic spms_word_t shift_in(input spms_word_t w, input logic lsb, input logic b);
      return lsb ? {b, w[WORD_BITS-1:1]} : {w[WORD_BITS-2:0], b};
   endfunction

   // ----------------------------------------
   // Pin synchronisers
   // ----------------------------------------
   logic [1:0] sck_sync, sel_sync, mosi_sync, miso_sync;
   logic       sck_prev;

   // Two stages, first stage read by nothing else; prev for edge finding
   always_ff @(posedge clock_in) begin
      if (!rst_n_in) begin
         sck_sync  <= 2'h0;
         sel_sync  <= 2'h3;
         mosi_sync <= 2'h0;
         miso_sync <= 2'h0;
         sck_prev  <= 1'b0;
      end else begin
         sck_sync  <= {sck_sync[0], sck_in};
         sel_sync  <= {sel_sync[0], sel_n_in};
         mosi_sync <= {mosi_sync[0], mosi_in};
         miso_sync <= {miso_sync[0], miso_in};
         sck_prev  <= sck_sync[1];
      end
   end

   logic s_rise, s_fall, s_sel;
   // Edges from synchronised clock only; one edge per two system clocks still resolves
   assign s_rise = sck_sync[1] & ~sck_prev;
   assign s_fall = ~sck_sync[1] & sck_prev;
   assign s_sel  = ~sel_sync[1];

   // ----------------------------------------
   // Two-entry output buffer
   // ----------------------------------------
   spms_word_t buf_mem [2];
   logic       buf_wp, buf_rp;
   logic [1:0] buf_cnt;
   logic       next_buf_wp, next_buf_rp;
   logic [1:0] next_buf_cnt;
   logic       push, pop;
   spms_word_t push_data;

   assign pop = rx_valid_out & rx_ready_in;

   // Pointer update; a full buffer stalls a new transfer, so nothing is dropped
   always_comb begin
      next_buf_wp  = buf_wp ^ push;
      next_buf_rp  = buf_rp ^ pop;
      next_buf_cnt = 2'(buf_cnt + {1'b0, push} - {1'b0, pop});
   end

   always_ff @(posedge clock_in) begin
      if (!rst_n_in) begin
         buf_wp  <= 1'b0;
         buf_rp  <= 1'b0;
         buf_cnt <= 2'h0;
      end else begin
         buf_wp  <= next_buf_wp;
         buf_rp  <= next_buf_rp;
         buf_cnt <= next_buf_cnt;
      end
      if (push) buf_mem[buf_wp] <= push_data;
   end

   // ----------------------------------------
   // Transfer engine
   // ----------------------------------------
   spms_state_t state, next_state;
   spms_word_t  tx_sh, next_tx_sh, rx_sh, next_rx_sh;
   logic [3:0]  bit_cnt, next_bit_cnt;
   logic [DIV_BITS-1:0] div_cnt, next_div_cnt;
   logic        is_master, next_is_master;
   logic        lsb, next_lsb;
   logic [2:0]  sel_idx, next_sel_idx;
   logic        next_sck, next_sck_oe, next_mosi, next_miso, next_miso_oe;
   logic [SEL_COUNT-1:0] next_sel_n;
   logic        next_tx_ready;
   logic [DIV_BITS-1:0] half_div;
   logic        room;
   // Delayed sample strobes: the line synchroniser lags two clocks behind the pin
   logic [1:0]  samp_pipe, next_samp_pipe;
   logic        rise_now;

   // Never below one system clock per half period
   assign half_div = (cfg_in.half_div < DIV_MIN) ? DIV_MIN : cfg_in.half_div;
   assign room     = (buf_cnt != 2'h2);

   // Next-state logic: mode 0, data out on falling edge, sampled on rising edge
   always_comb begin
      next_state     = state;
      next_tx_sh     = tx_sh;
      next_rx_sh     = rx_sh;
      next_bit_cnt   = bit_cnt;
      next_div_cnt   = div_cnt;
      next_is_master = is_master;
      next_lsb       = lsb;
      next_sel_idx   = sel_idx;
      next_sck       = 1'b0;
      next_sck_oe    = is_master;
      next_sel_n     = SEL_IDLE;
      next_mosi      = mosi_out;
      next_miso      = miso_out;
      next_miso_oe   = 1'b0;
      next_tx_ready  = 1'b0;
      push           = 1'b0;
      push_data      = rx_sh;
      rise_now       = 1'b0;
      // Master takes the line as it stood at its rising edge, two flops later
      if (samp_pipe[1]) next_rx_sh = shift_in(rx_sh, lsb, miso_sync[1]);
      case (state)
         ST_IDLE: begin
            next_is_master = cfg_in.master;
            next_lsb       = cfg_in.lsb_first;
            next_sel_idx   = cfg_in.sel_index;
            next_sck_oe    = cfg_in.master;
            next_bit_cnt   = BIT_CNT_RST;
            next_div_cnt   = half_div;
            next_tx_ready  = room;
            // Master needs a word; slave waits for an external select
            if (room && tx_valid_in && tx_ready_out && (cfg_in.master || s_sel)) begin
               next_tx_sh    = tx_data_in;
               next_tx_ready = 1'b0;
               next_state    = ST_LOW;
               if (cfg_in.master) begin
                  next_sel_n[cfg_in.sel_index] = 1'b0;
                  next_mosi = pick_bit(tx_data_in, BIT_CNT_RST, cfg_in.lsb_first);
               end else begin
                  next_miso_oe = 1'b1;
                  next_miso    = pick_bit(tx_data_in, BIT_CNT_RST, cfg_in.lsb_first);
               end
            end
         end
         ST_LOW, ST_HIGH: begin
            if (is_master) begin
               next_sel_n[sel_idx] = 1'b0;
               next_sck = (state == ST_HIGH);
               next_div_cnt = 8'(div_cnt - 8'h01);
               if (div_cnt == DIV_MIN) begin
                  next_div_cnt = half_div;
                  if (state == ST_LOW) begin
                     next_sck   = 1'b1;
                     rise_now   = 1'b1;                  // Sample lands two clocks on
                     next_state = ST_HIGH;
                  end else begin
                     next_sck     = 1'b0;
                     next_bit_cnt = 4'(bit_cnt + 4'h1);
                     next_mosi    = pick_bit(tx_sh, 4'(bit_cnt + 4'h1), lsb);
                     next_state   = (bit_cnt == BIT_LAST - 4'h1) ? ST_DONE : ST_LOW;
                  end
               end
            end else begin
               next_miso_oe = s_sel;
               // Select dropped early: abandon the word
               if (!s_sel) begin
                  next_state = ST_IDLE;
               end else if (s_rise) begin
                  next_rx_sh   = put_bit(rx_sh, bit_cnt, lsb, mosi_sync[1]);
                  next_bit_cnt = 4'(bit_cnt + 4'h1);
                  if (bit_cnt == BIT_LAST - 4'h1) next_state = ST_DONE;
               end else if (s_fall) begin
                  next_miso = pick_bit(tx_sh, bit_cnt, lsb);
               end
            end
         end
         ST_DONE: begin
            // Wait out the last delayed sample, then hand word over; select released
            next_miso_oe = ~is_master & s_sel;
            if (samp_pipe == 2'h0) begin
               push       = 1'b1;
               next_state = ST_IDLE;
            end
         end
         default: next_state = ST_IDLE;
      endcase
      next_samp_pipe = {samp_pipe[0], rise_now};
   end

   // Registers of the engine and pins; all outputs from flip-flops
   always_ff @(posedge clock_in) begin
      if (!rst_n_in) begin
         state        <= ST_IDLE;
         tx_sh        <= '0;
         rx_sh        <= '0;
         bit_cnt      <= BIT_CNT_RST;
         div_cnt      <= DIV_MIN;
         is_master    <= 1'b0;
         lsb          <= 1'b0;
         sel_idx      <= 3'h0;
         samp_pipe    <= 2'h0;
         sck_out      <= 1'b0;
         sck_oe_out   <= 1'b0;
         sel_n_out    <= SEL_IDLE;
         mosi_out     <= 1'b0;
         miso_out     <= 1'b0;
         miso_oe_out  <= 1'b0;
         tx_ready_out <= 1'b0;
         rx_data_out  <= '0;
         rx_valid_out <= 1'b0;
      end else begin
         state        <= next_state;
         tx_sh        <= next_tx_sh;
         rx_sh        <= next_rx_sh;
         bit_cnt      <= next_bit_cnt;
         div_cnt      <= next_div_cnt;
         is_master    <= next_is_master;
         lsb          <= next_lsb;
         sel_idx      <= next_sel_idx;
         samp_pipe    <= next_samp_pipe;
         sck_out      <= next_sck;
         sck_oe_out   <= next_sck_oe;
         sel_n_out    <= next_sel_n;
         mosi_out     <= next_mosi;
         miso_out     <= next_miso;
         miso_oe_out  <= next_miso_oe;
         tx_ready_out <= next_tx_ready;
         // Output stage shows head of buffer in the same cycle, taken from next count and read pointer
         rx_valid_out <= (next_buf_cnt != 2'h0);
         rx_data_out  <= (buf_cnt == 2'h0 || (pop && buf_cnt == 2'h1)) ? push_data
                         : buf_mem[next_buf_rp];
      end
   end

endmodule

// ---- dv/spms_core_sva.sv ----
// Port assertions for the serial core
`timescale 1ns/1ns
module spms_core_sva
   import spms_pkg::*;
(
   // Watched ports
   input wire logic                 clock_in,
   input wire logic                 rst_n_in,
   input wire spms_pkg::spms_cfg_t  cfg_in,
   input wire logic                 rx_ready_in,
   input wire logic                 rx_valid_out,
   input wire spms_pkg::spms_word_t rx_data_out,
   input wire logic                 sck_out,
   input wire logic [SEL_COUNT-1:0] sel_n_out
);
   default clocking @(posedge clock_in); endclocking
   default disable iff (!rst_n_in);
   // ---
   // Selects and serial clock
   // ---
   AST_SEL_ONE:
      assert property ($countones(~sel_n_out) <= 1) else $error("two selects low");
   AST_SEL_IDX:
      assert property (sel_n_out != SEL_IDLE |-> !sel_n_out[cfg_in.sel_index]) else $error("wrong select");
   AST_SCK_SEL:
      assert property (sck_out |-> sel_n_out != SEL_IDLE) else $error("clock without select");
   AST_SLV_QUIET:
      assert property (!cfg_in.master && !$past(cfg_in.master) |-> !sck_out) else $error("slave drives clock");
   AST_SCK_DIV:
      assert property ($rose(sck_out) && cfg_in.half_div == 8'h02 |=> sck_out) else $error("clock high too short");
   // Reset leaves selects idle, even across a second reset
   AST_RST_IDLE:
      assert property (disable iff (1'h0) !rst_n_in |=> sel_n_out == SEL_IDLE && !sck_out) else $error("reset not idle");
   // Stalled word must stand unchanged
   AST_RX_HOLD:
      assert property (rx_valid_out && !rx_ready_in |=> rx_valid_out && $stable(rx_data_out)) else $error("word lost");
   cover property ($rose(sck_out));
   cover property ($fell(sel_n_out[7]));
   cover property (rx_valid_out && !rx_ready_in ##1 rx_valid_out);
endmodule

// ---- dv/spms_peer.sv ----
// Behavioural slave device on the master port
`timescale 1ns/1ns
module spms_peer
   import spms_pkg::*;
(
   // Serial side
   input  wire logic                 sck_in,
   input  wire logic                 sel_n_in,
   input  wire logic                 mosi_in,
   output logic                      miso_out,
   // Bench side
   input  wire logic                 lsb_first_in,
   input  wire spms_pkg::spms_word_t tx_data_in,
   output spms_pkg::spms_word_t      rx_data_out
);
   spms_word_t sh;
   initial miso_out = 1'h0;
   // First bit ready before first rising edge
   always @(negedge sel_n_in) begin
      sh = tx_data_in;
      miso_out = lsb_first_in ? sh[0] : sh[7];
   end
   // Mode 0: sample rising, shift falling
   always @(posedge sck_in) begin
      if (!sel_n_in) rx_data_out = lsb_first_in ? {mosi_in, rx_data_out[7:1]} : {rx_data_out[6:0], mosi_in};
   end
   always @(negedge sck_in) begin
      if (!sel_n_in) begin
         sh = lsb_first_in ? sh >> 1 : sh << 1;
         miso_out = lsb_first_in ? sh[0] : sh[7];
      end
   end
   // Released line is not a copy of the last bit
   always @(posedge sel_n_in) miso_out = ~miso_out;
endmodule

// ---- dv/spms_core_bench.sv ----
// Self-checking bench for the serial core in both modes
`timescale 1ns/1ns
module spms_core_bench;
   import spms_pkg::*;
   logic clock_in = 1'h0, rst_n_in = 1'h0, tx_valid_in = 1'h0, rx_ready_in = 1'h0;
   logic sck_in = 1'h0, sel_n_in = 1'h1, mosi_in = 1'h0, miso_in;
   logic tx_ready_out, rx_valid_out, sck_out, sck_oe_out, mosi_out, miso_out, miso_oe_out;
   logic [SEL_COUNT-1:0] sel_n_out;
   spms_cfg_t cfg_in = '0;
   spms_word_t tx_data_in = '0, peer_tx = '0, rx_data_out, peer_rx;
   int bad_count = 0, n_tests = 0;
   spms_core spms_core_inst (.clock_in, .rst_n_in, .cfg_in, .tx_data_in, .tx_valid_in, .tx_ready_out,
      .rx_data_out, .rx_valid_out, .rx_ready_in, .sck_out, .sck_oe_out, .sel_n_out, .mosi_out,
      .miso_out, .miso_oe_out, .sck_in, .sel_n_in, .mosi_in, .miso_in);
   spms_peer spms_peer_inst (.sck_in(sck_out), .sel_n_in(sel_n_out[cfg_in.sel_index]), .mosi_in(mosi_out),
      .miso_out(miso_in), .lsb_first_in(cfg_in.lsb_first), .tx_data_in(peer_tx), .rx_data_out(peer_rx));
   always #10 clock_in = ~clock_in;
   // ---
   // Shared tasks
   // ---
   task automatic check(string name, spms_word_t seen, spms_word_t exp);
      n_tests++;
      if (seen !== exp) begin
         bad_count++;
         $display("mismatch %s expected %h seen %h", name, exp, seen);
      end
   endtask
   function automatic logic bit_of(spms_word_t w, int i, logic lsb);
      return lsb ? w[i] : w[7 - i];
   endfunction
   task automatic wait_neg(int n);
      repeat (n) @(negedge clock_in);
   endtask
   // Hold valid until ready seen, bounded
   task automatic send(spms_word_t w);
      tx_data_in = w;
      tx_valid_in = 1'h1;
      for (int k = 0; k < 2000 && tx_ready_out !== 1'h1; k++) @(negedge clock_in);
      if (tx_ready_out !== 1'h1) bad_count++;
      @(negedge clock_in);
      tx_valid_in = 1'h0;
   endtask
   task automatic recv(output spms_word_t d);
      for (int k = 0; k < 2000 && rx_valid_out !== 1'h1; k++) @(negedge clock_in);
      if (rx_valid_out !== 1'h1) bad_count++;
      d = rx_data_out;
      rx_ready_in = 1'h1;
      @(negedge clock_in);
      rx_ready_in = 1'h0;
   endtask
   task automatic end_sim;
      $display("tests %0d mismatches %0d", n_tests, bad_count);
      if (bad_count == 0 && n_tests > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   // ---
   // Scenarios
   // ---
   initial begin
      spms_word_t w, m, d, g;
      void'($urandom(32'h059f799c));
      cfg_in.master = 1'h1;
      wait_neg(20);
      rst_n_in = 1'h1;
      wait_neg(2);
      // Master: every select, both orders, divisors 1, 0 and 2 as corners
      for (int i = 0; i < 8; i++) begin
         cfg_in.lsb_first = i[0];
         cfg_in.sel_index = i[2:0];
         cfg_in.half_div = (i == 0) ? 8'h01 : (i == 1) ? 8'h00 : (i == 2) ? 8'h02 : 8'($urandom_range(4, 1));
         w = 8'($urandom);
         peer_tx = 8'($urandom);
         wait_neg(2);
         send(w);
         for (int k = 0; k < 50 && sel_n_out === SEL_IDLE; k++) @(negedge clock_in);
         check("select", sel_n_out, 8'(~(8'h01 << i)));
         check("clock enable", {7'h0, sck_oe_out}, 8'h01);
         recv(d);
         check("master rx", d, peer_tx);
         check("peer rx", peer_rx, w);
      end
      // Receiver stalls: two words held, third refused
      peer_tx = 8'h69;
      send(8'ha5);
      peer_tx = 8'h96;
      send(8'h3c);
      wait_neg(200);
      check("ready full", {7'h0, tx_ready_out}, 8'h00);
      tx_data_in = 8'hff;
      tx_valid_in = 1'h1;
      wait_neg(20);
      check("refused select", sel_n_out, SEL_IDLE);
      tx_valid_in = 1'h0;
      recv(d);
      check("held first", d, 8'h69);
      recv(d);
      check("held second", d, 8'h96);
      check("peer last", peer_rx, 8'h3c);
      // Slave: select dropped mid-word, nothing handed over
      cfg_in.master = 1'h0;
      sel_n_in = 1'h0;
      wait_neg(4);
      send(8'h81);
      for (int b = 0; b < 3; b++) begin
         sck_in = 1'h1;
         wait_neg(4);
         sck_in = 1'h0;
         wait_neg(4);
      end
      sel_n_in = 1'h1;
      wait_neg(8);
      check("abandon", {7'h0, rx_valid_out}, 8'h00);
      // Slave: 160 ns link clock, then at half the system clock
      for (int i = 0; i < 4; i++) begin
         cfg_in.lsb_first = i[0];
         w = 8'($urandom);
         m = 8'($urandom);
         wait_neg(4);
         sel_n_in = 1'h0;
         wait_neg(4);
         send(w);
         check("slave drive", {6'h0, sck_oe_out, miso_oe_out}, 8'h01);
         wait_neg(4);
         for (int b = 0; b < 8; b++) begin
            mosi_in = bit_of(m, b, cfg_in.lsb_first);
            wait_neg(i < 2 ? 4 : 1);
            sck_in = 1'h1;
            g[cfg_in.lsb_first ? b : 7 - b] = miso_out;
            wait_neg(i < 2 ? 4 : 1);
            sck_in = 1'h0;
         end
         wait_neg(4);
         sel_n_in = 1'h1;
         mosi_in = ~mosi_in;
         recv(d);
         check("slave rx", d, m);
         if (i < 2) check("slave tx", g, w);
      end
      end_sim;
   end
   // Hang guard, well past the expected run
   initial begin
      #400000;
      bad_count++;
      end_sim;
   end
endmodule
bind spms_core spms_core_sva spms_core_sva_inst (.clock_in, .rst_n_in, .cfg_in, .rx_ready_in,
   .rx_valid_out, .rx_data_out, .sck_out, .sel_n_out);
